// ---- common/wpr_pkg.sv ----
package wpr_pkg;
  // Register map, bus address width 12
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_INDEX = 12'h000b;
  localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX[9:0], 2'b00};
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0030;
  localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h0034;
  localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h0038;
  // Control register fields
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 3;
  localparam int CLEAR_BIT = 0;
  localparam int IRQ_EVT_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Counter
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_CLEARED = 16'hffff;
  localparam int SEL_BASE_N = 10;
  localparam int WDT_TAP_BIT = 15;
  // Nominal source rates, for reference of the period table
  localparam int SUBCLK_HZ = 32768;
  localparam int RC_CLK_HZ = 100000;
  localparam int SYS_CLK_HZ = 100000000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// ---- hdl/wpr_edge_sync.sv ----
`timescale 1ns/1ps
module wpr_edge_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic rise
);
  logic s1, s2, s3, stable;
  logic next_stable, next_rise;

  always_comb begin
    next_stable = stable;
    next_rise = 1'b0;
    // Only agreed samples count, so a metastable settle is ignored
    if (s2 == s3) begin
      next_stable = s3;
      next_rise = s3 & ~stable;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      stable <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
      rise <= next_rise;
    end
  end
endmodule // wpr_edge_sync

// ---- hdl/wpr_interval_prescaler.sv ----
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Behaviour
// [RQ1] Sixteen-bit free-running down-counter stepping once per halved source clock.
// [RQ2] Interval event repeats every selected period without software restart.
// [RQ3] Selector picks one of eight counter bits as the event source.
// [RQ4] Select value s gives period 2^(s+10) times two source periods.
// [RQ5] Periods span 62.5 ms-8 s on subclock, 20.48 ms-2.621 s on RC.
// [RQ6] Writing one to clear bit resets counter; zero ignored; reads zero.
// [RQ7] Hardware sets elapsed flag on interval; writing one leaves it.
// [RQ8] Writing zero clears elapsed flag; zero means interval not elapsed.
// [RQ9] Read-modify-write reads of elapsed flag return one.
// [RQ10] Interrupt output high only while flag and enable both one.
// [RQ11] Bits 5 and 4 read zero and ignore writes.
// [RQ12] Control layout flag7, enable6, select3..1, clear0; resets to zero.
// [RQ13] A counter-derived clock tap feeds the watchdog count input.
// [RQ14] Clearing the counter also pulses a watchdog clear.
// [RQ15] Source choice comes from a clock-control input, not the register.
// [RQ16] After a clear the next event comes one full period later.
module wpr_interval_prescaler (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rmw_read,
  input wire logic subclk_pin,
  input wire logic rc_clk_pin,
  input wire logic src_is_rc,
  output logic irq,
  output logic wdt_clk_tap,
  output logic wdt_clear
);
  typedef enum logic [1:0] {
    WPR_IDLE = 2'b01,
    WPR_RESP = 2'b10
  } wpr_bus_state_t;

  wpr_bus_state_t state, next_state;
  logic sub_rise, rc_rise, src_rise;
  logic half, next_half;
  logic count_tick;
  logic [15:0] cnt, next_cnt;
  logic cnt_ext, next_cnt_ext;
  logic [16:0] cnt_full;
  logic [16:0] low_mask;
  logic [4:0] sel_bit;
  logic interval_event;
  logic flag, next_flag;
  logic irq_en, next_irq_en;
  logic [2:0] sel, next_sel;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_irq, next_wdt_tap, next_wdt_clear;
  logic wr_fire, rd_now, hit;
  logic clear_req;

  wpr_edge_sync u_sub_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(subclk_pin),
    .rise(sub_rise)
  );

  wpr_edge_sync u_rc_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(rc_clk_pin),
    .rise(rc_rise)
  );

  // [RQ15] Source from clock control
  assign src_rise = src_is_rc ? rc_rise : sub_rise;

  // [RQ1] Halve the source
  assign count_tick = src_rise & half;

  // [RQ3] Select event bit
  assign sel_bit = 5'(sel) + 5'(wpr_pkg::SEL_BASE_N - 1);
  // [RQ5] Period doubles per step
  assign low_mask = 17'h1_ffff >> (5'h10 - sel_bit);
  // Top select needs a seventeenth bit beyond the counter
  assign cnt_full = {cnt_ext, cnt};

  // [RQ4] Event on borrow through bit
  assign interval_event = count_tick & ((cnt_full & low_mask) == 17'h0_0000) & ~clear_req;

  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_now = psel & penable & ~pready & ~pwrite;
  assign clear_req = wr_fire & (paddr == wpr_pkg::CTRL_ADDR) & pwdata[wpr_pkg::CLEAR_BIT];
  assign hit = (paddr == wpr_pkg::CTRL_ADDR) || (paddr == wpr_pkg::IRQ_STATUS_ADDR) ||
               (paddr == wpr_pkg::IRQ_CLEAR_ADDR) || (paddr == wpr_pkg::IRQ_ENABLE_ADDR);

  always_comb begin
    next_half = half;
    next_cnt = cnt;
    next_cnt_ext = cnt_ext;
    if (src_rise) begin
      next_half = ~half;
    end
    // [RQ6] Clear reloads counter
    if (clear_req) begin
      // [RQ16] Full period from clear
      next_cnt = wpr_pkg::CNT_CLEARED;
      next_cnt_ext = 1'b1;
      next_half = 1'b0;
    end else if (count_tick) begin
      // [RQ2] Free-running wrap
      next_cnt = cnt - 16'h0001;
      if (cnt == 16'h0000) begin
        next_cnt_ext = ~cnt_ext;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      half <= 1'b0;
      cnt <= wpr_pkg::CNT_CLEARED;
      cnt_ext <= 1'b1;
    end else begin
      half <= next_half;
      cnt <= next_cnt;
      cnt_ext <= next_cnt_ext;
    end
  end

  always_comb begin
    next_flag = flag;
    next_irq_en = irq_en;
    next_sel = sel;
    if (wr_fire && paddr == wpr_pkg::CTRL_ADDR) begin
      // [RQ8] Zero clears flag, one ignored
      if (!pwdata[wpr_pkg::FLAG_BIT]) begin
        next_flag = 1'b0;
      end
      next_irq_en = pwdata[wpr_pkg::IRQ_EN_BIT];
      next_sel = pwdata[wpr_pkg::SEL_MSB:wpr_pkg::SEL_LSB];
    end
    if (wr_fire && paddr == wpr_pkg::IRQ_CLEAR_ADDR && pwdata[wpr_pkg::IRQ_EVT_BIT]) begin
      next_flag = 1'b0;
    end
    if (wr_fire && paddr == wpr_pkg::IRQ_ENABLE_ADDR) begin
      next_irq_en = pwdata[wpr_pkg::IRQ_EVT_BIT];
    end
    // [RQ7] Set wins over clear
    if (interval_event) begin
      next_flag = 1'b1;
    end
  end

  always_comb begin
    next_prdata = wpr_pkg::RD_ZERO;
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      WPR_IDLE: begin
        if (psel && penable) begin
          next_state = WPR_RESP;
          next_pready = 1'b1;
          next_pslverr = ~hit;
          if (rd_now && paddr == wpr_pkg::CTRL_ADDR) begin
            // [RQ11] Unimplemented bits and clear read zero
            next_prdata[wpr_pkg::SEL_MSB:wpr_pkg::SEL_LSB] = sel;
            next_prdata[wpr_pkg::IRQ_EN_BIT] = irq_en;
            // [RQ9] Modify reads see one
            next_prdata[wpr_pkg::FLAG_BIT] = flag | rmw_read;
          end else if (rd_now && paddr == wpr_pkg::IRQ_STATUS_ADDR) begin
            next_prdata[wpr_pkg::IRQ_EVT_BIT] = flag;
          end else if (rd_now && paddr == wpr_pkg::IRQ_ENABLE_ADDR) begin
            next_prdata[wpr_pkg::IRQ_EVT_BIT] = irq_en;
          end
        end
      end
      WPR_RESP: begin
        next_state = WPR_IDLE;
      end
      default: begin
        next_state = WPR_IDLE;
      end
    endcase
    // [RQ10] Gate by enable
    next_irq = next_flag & next_irq_en;
    // [RQ13] Watchdog tap from counter
    next_wdt_tap = next_cnt[wpr_pkg::WDT_TAP_BIT];
    // [RQ14] Watchdog clear with counter
    next_wdt_clear = clear_req;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // [RQ12] Reset to zero
      flag <= wpr_pkg::CTRL_RESET[wpr_pkg::FLAG_BIT];
      irq_en <= wpr_pkg::CTRL_RESET[wpr_pkg::IRQ_EN_BIT];
      sel <= wpr_pkg::CTRL_RESET[wpr_pkg::SEL_MSB:wpr_pkg::SEL_LSB];
      state <= WPR_IDLE;
      prdata <= wpr_pkg::RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      wdt_clk_tap <= 1'b1;
      wdt_clear <= 1'b0;
    end else begin
      flag <= next_flag;
      irq_en <= next_irq_en;
      sel <= next_sel;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      wdt_clk_tap <= next_wdt_tap;
      wdt_clear <= next_wdt_clear;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_ctrl_write;
    psel && penable && pready && pwrite && paddr == wpr_pkg::CTRL_ADDR;
  endsequence

  sequence s_ctrl_read;
    psel && penable && !pready && !pwrite && paddr == wpr_pkg::CTRL_ADDR;
  endsequence

  sequence s_status_read;
    psel && penable && !pready && !pwrite && paddr == wpr_pkg::IRQ_STATUS_ADDR;
  endsequence

  a_irq_gated_level: assert property (irq == (flag && irq_en)) // [RQ10]
    else $error("irq differs from flag and enable");

  a_count_step_down: assert property (count_tick && !clear_req |=> cnt == $past(cnt) - 16'h0001) // [RQ1]
    else $error("counter did not step down by one");

  a_clear_reload: assert property (s_ctrl_write ##0 pwdata[0] |=> cnt == 16'hffff && wdt_clear) // [RQ6]
    else $error("clear did not reload counter and pulse watchdog clear");

  a_event_sets_flag: assert property (interval_event |=> flag ##1 1'b1) // [RQ7]
    else $error("interval event did not set flag");

  a_flag_one_ignored: assert property
    (s_ctrl_write ##0 pwdata[7] && !flag && !interval_event |=> !flag) // [RQ7]
    else $error("writing one changed the flag");

  a_flag_zero_clears: assert property
    (s_ctrl_write ##0 !pwdata[7] && !interval_event |=> !flag) // [RQ8]
    else $error("writing zero did not clear the flag");

  a_rsvd_read_zero: assert property (s_ctrl_read |=> prdata[5:4] == 2'b00 && !prdata[0] && pready) // [RQ11]
    else $error("unimplemented or clear bits read non-zero");

  a_rmw_reads_one: assert property (s_ctrl_read ##0 rmw_read |=> prdata[7]) // [RQ9]
    else $error("modify read did not return one for flag");

  a_event_from_select: assert property
    (interval_event |-> ({cnt_ext, cnt} & (17'h1_ffff >> (5'h07 - 5'(sel)))) == 17'h0_0000)
    else $error("event not at selected counter bit");

  a_wdt_tap_follows: assert property (wdt_clk_tap == cnt[15]) // [RQ13]
    else $error("watchdog tap not following counter");

  a_select_written: assert property (s_ctrl_write |=> sel == $past(pwdata[3:1])) // [RQ4]
    else $error("interval select not taken from write");

  a_enable_written: assert property (s_ctrl_write |=> irq_en == $past(pwdata[6])) // [RQ10]
    else $error("interrupt enable not taken from write");

  a_clear_full_reload: assert property // [RQ16]
    (s_ctrl_write ##0 pwdata[0] |=> {cnt_ext, cnt} == 17'h1_ffff)
    else $error("clear did not reload the full period");

  a_wdt_clear_cause: assert property (wdt_clear |-> $past(clear_req)) // [RQ14]
    else $error("watchdog clear without counter clear");

  a_zero_clear_idle: assert property // [RQ6]
    (s_ctrl_write ##0 !pwdata[0] && !count_tick |=> cnt == $past(cnt))
    else $error("writing zero to clear changed the counter");

  a_flag_sticky: assert property (!interval_event && !wr_fire |=> flag == $past(flag)) // [RQ7]
    else $error("flag changed without event or write");

  a_status_read_flag: assert property (s_status_read |=> prdata[0] == $past(flag)) // [RQ7]
    else $error("status read does not show the flag");

  a_rc_source_step: assert property // [RQ15]
    (src_is_rc && rc_rise && half && !clear_req |=> cnt == $past(cnt) - 16'h0001)
    else $error("counter did not step on the RC source");

  a_rc_ignores_sub: assert property // [RQ15]
    (src_is_rc && !rc_rise && !clear_req |=> cnt == $past(cnt))
    else $error("counter stepped without an RC edge");

  a_half_skips_edge: assert property (src_rise && !half && !clear_req |=> cnt == $past(cnt)) // [RQ1]
    else $error("counter stepped on an odd source edge");

  a_slverr_unmapped: assert property (pready |-> pslverr == !hit) // [RQ12]
    else $error("error response does not match the address map");
endmodule // wpr_interval_prescaler

// ---- tb/tb_subclock_interval_prescaler.sv ----
`timescale 1ns/1ps
module tb_subclock_interval_prescaler;
  logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, rmw_read = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, subclk_pin = 0, rc_clk_pin = 0, src_is_rc = 0;
  logic irq, wdt_clk_tap, wdt_clear;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [7:0] rs = 8'h3f;
  int errors = 0, num_checks = 0, cyc = 0, irq_count, wdt_count, clear_count;
  wpr_interval_prescaler DUT (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rmw_read(rmw_read), .subclk_pin(subclk_pin),
    .rc_clk_pin(rc_clk_pin), .src_is_rc(src_is_rc), .irq(irq),
    .wdt_clk_tap(wdt_clk_tap), .wdt_clear(wdt_clear));
  wpr_partner partner (.sys_clk(sys_clk), .arst_n(arst_n), .irq(irq),
    .wdt_clk_tap(wdt_clk_tap), .wdt_clear(wdt_clear), .irq_count(irq_count),
    .wdt_count(wdt_count), .clear_count(clear_count));
  always #5 sys_clk = ~sys_clk;
  // Free-running sources, phase unrelated to sys_clk
  always #83 subclk_pin <= ~subclk_pin;
  always #53 rc_clk_pin <= ~rc_clk_pin;
  function automatic logic [7:0] xs(input logic [7:0] v);
    v = v ^ (v << 3);
    v = v ^ (v >> 5);
    return v ^ (v << 1);
  endfunction
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic er, input logic [31:0] x, input logic rmw);
    q.push_back({!w, er, x});
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rmw_read <= rmw;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    rmw_read <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 0, 0, 0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic rmw);
    apb(0, a, 0, 0, x, rmw);
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  // Monitor takes the oldest note per answer
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
    cyc++;
    if (cyc > 90000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1;
    rd(wpr_pkg::CTRL_ADDR, 32'h0000_0000, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      wr(wpr_pkg::CTRL_ADDR, {24'h0, rs[7:4], i[2:0], 1'b0});
      rd(wpr_pkg::CTRL_ADDR, {24'h0, 1'b0, rs[6], 2'b00, i[2:0], 1'b0}, 0);
    end
    apb(0, 12'h100, 0, 1, 0, 0);
    $display("test fields done");
    wr(wpr_pkg::CTRL_ADDR, 32'h0000_0041);
    repeat (3) @(posedge sys_clk);
    check("wdt clear", clear_count, 1);
    check("wdt count", wdt_count, 0);
    check("tap", {31'h0, wdt_clk_tap}, 1);
    repeat (30000) @(posedge sys_clk);
    rd(wpr_pkg::CTRL_ADDR, 32'h0000_0040, 0);
    rd(wpr_pkg::CTRL_ADDR, 32'h0000_00c0, 1);
    check("irq early", {31'h0, irq}, 0);
    wait_irq(4000);
    check("irq", {31'h0, irq}, 1);
    rd(wpr_pkg::CTRL_ADDR, 32'h0000_00c0, 0);
    rd(wpr_pkg::IRQ_STATUS_ADDR, 32'h0000_0001, 0);
    wr(wpr_pkg::CTRL_ADDR, 32'h0000_0040);
    rd(wpr_pkg::CTRL_ADDR, 32'h0000_0040, 0);
    src_is_rc <= 1;
    $display("test interval done");
    wait_irq(23000);
    check("irq count", irq_count, 2);
    wr(wpr_pkg::IRQ_CLEAR_ADDR, 32'h0000_0001);
    rd(wpr_pkg::IRQ_STATUS_ADDR, 32'h0000_0000, 0);
    wr(wpr_pkg::IRQ_ENABLE_ADDR, 32'h0000_0000);
    rd(wpr_pkg::CTRL_ADDR, 32'h0000_0000, 0);
    check("irq off", {31'h0, irq}, 0);
    $display("test repeat done");
    complete_run();
  end
endmodule // tb_subclock_interval_prescaler

// ---- tb/wpr_partner.sv ----
`timescale 1ns/1ps
module wpr_partner (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic irq,
  input wire logic wdt_clk_tap,
  input wire logic wdt_clear,
  output int irq_count,
  output int wdt_count,
  output int clear_count
);
  logic irq_d;
  logic tap_d;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_d <= 1'b0;
      tap_d <= 1'b1;
      irq_count <= 0;
      wdt_count <= 0;
      clear_count <= 0;
    end else begin
      irq_d <= irq;
      tap_d <= wdt_clk_tap;
      if (irq && !irq_d) irq_count <= irq_count + 1;
      if (wdt_clear) begin
        wdt_count <= 0;
        clear_count <= clear_count + 1;
      end else if (wdt_clk_tap && !tap_d) wdt_count <= wdt_count + 1;
    end
  end
endmodule // wpr_partner
